// ---- design/port_ctl_pkg.sv ----
// Shared constants and carrier types of the host port control registers.
// Assumes a single clock domain and a plain strobe-based register port.
package port_ctl_pkg;

	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] OFS_CONTROL = 8'h30;
	localparam logic [7:0] OFS_WRITE_ADDR = 8'h34;
	localparam logic [7:0] OFS_READ_ADDR = 8'h38;
	localparam logic [7:0] OFS_SOFT_RESET = 8'h3c;
	localparam logic [7:0] OFS_OWNERSHIP = 8'h40;

	// ----------------------------------------
	// Control register fields
	// ----------------------------------------
	localparam int BIT_ADDR_SEL = 11;
	localparam int BIT_DUAL_MODE = 9;
	localparam int BIT_HWO_STATUS = 8;
	localparam int BIT_FETCH = 4;
	localparam int BIT_RSVD_ONE = 3;
	localparam int BIT_HOST_INT = 2;
	localparam int BIT_PROC_INT = 1;
	localparam int BIT_HWO = 0;

	// ----------------------------------------
	// Ownership and time-out register fields
	// ----------------------------------------
	localparam int BIT_CTL_OWNER = 9;
	localparam int BIT_ADDR_OWNER = 8;
	localparam int TIMEOUT_W = 8;
	localparam logic [7:0] TIMEOUT_RESET = 8'h00;

	// Soft reset register
	localparam int BIT_SOFT_RESET = 0;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [31:0] ADDR_RESET = 32'h0000_0000;

	// ----------------------------------------
	// Carrier types
	// ----------------------------------------
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} reg_req_t;

endpackage

// ---- design/sticky_flag.sv ----
// One flag with independent set and clear requests.
// Assumes both requests come from logic on the same clock.
module sticky_flag (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic set,
	input wire logic clr,
	output logic q
);

	logic q_d;

	// A set in the same cycle as a clear wins, so no event is lost
	assign q_d = set | (q & ~clr);

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= 1'b0;
		end else begin
			q <= q_d;
		end
	end

endmodule

// ---- design/addr_pair.sv ----
// Two address registers, entry 0 for writes and entry 1 for reads.
// Assumes write enables are already resolved for ownership and mode.
module addr_pair
	import port_ctl_pkg::*;
#(
	parameter int ADDR_W = 32
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic soft_rst,
	input wire logic [1:0] we,
	input wire logic [ADDR_W-1:0] wdata,
	output logic [1:0][ADDR_W-1:0] q
);

	for (genvar i = 0; i < 2; i++) begin : g_entry
		always_ff @(posedge ref_clk or negedge arst_n) begin
			if (!arst_n) begin
				q[i] <= ADDR_RESET[ADDR_W-1:0];
			end else if (soft_rst) begin
				q[i] <= ADDR_RESET[ADDR_W-1:0];
			end else if (we[i]) begin
				q[i] <= wdata;
			end
		end
	end

endmodule

// ---- design/host_port_control_regs.sv ----
// Control, address and ownership registers of the parallel host port.
// Assumes the host strobe protocol has already been turned into a
// same-clock register port; both ports answer reads one cycle later.
//
// How it works
// - In dual mode, bit 11 picks address register
// - Dual bit clear, host owning addresses: one shared address register
// - Processor always sees both address registers
// - Bit 8 mirrors halfword order on writes
// - Host write 1 to bit 4 prefetches
// - Prefetch bit always reads zero
// - Processor write 1 to bit 2 interrupts host
// - Host write 1 clears host interrupt
// - Host write 1 to bit 1 interrupts processor
// - Bit 0 sets halfword order
// - Two full 32-bit address registers
// - Ownership register survives soft reset
// - Bit 9 with bit 8 gives control write ownership
// - Bit 8 gives address write ownership
// - Bits 7-0 hold burst write time-out
// - Non-owner may raise interrupt, soft reset
// - Hardware reset clears host interrupt immediately
//
// The address-and-strobe port and the register addresses are this design's own decisions.
module host_port_control_regs
	import port_ctl_pkg::*;
#(
	parameter int ADDR_W = 32
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire reg_req_t cpu_req,
	output logic [31:0] cpu_rdata,
	input wire reg_req_t host_req,
	output logic [31:0] host_rdata,
	output logic host_int_n,
	output logic proc_irq,
	output logic fetch_req,
	output logic port_soft_reset,
	output logic halfword_order,
	output logic [TIMEOUT_W-1:0] burst_write_timeout,
	output logic [ADDR_W-1:0] write_address,
	output logic [ADDR_W-1:0] read_address
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic address_reg_select_q;
	logic dual_address_mode_q;
	logic halfword_order_q;
	logic halfword_order_status_q;
	logic control_write_owner_q;
	logic address_write_owner_q;
	logic [TIMEOUT_W-1:0] burst_write_timeout_q;
	logic host_int_n_q;
	logic fetch_req_q;
	logic soft_rst_q;
	logic [31:0] cpu_rdata_q;
	logic [31:0] host_rdata_q;
	logic host_int_flag;
	logic proc_int_flag;
	logic [1:0][ADDR_W-1:0] addr_q;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire cpu_wr_ctl = cpu_req.wr && cpu_req.addr == OFS_CONTROL;
	wire cpu_wr_aw = cpu_req.wr && cpu_req.addr == OFS_WRITE_ADDR;
	wire cpu_wr_ar = cpu_req.wr && cpu_req.addr == OFS_READ_ADDR;
	wire cpu_wr_rst = cpu_req.wr && cpu_req.addr == OFS_SOFT_RESET;
	wire cpu_wr_own = cpu_req.wr && cpu_req.addr == OFS_OWNERSHIP;
	wire host_wr_ctl = host_req.wr && host_req.addr == OFS_CONTROL;
	wire host_wr_addr = host_req.wr && host_req.addr == OFS_WRITE_ADDR;
	wire host_wr_rst = host_req.wr && host_req.addr == OFS_SOFT_RESET;

	// Processor owns control only if it also owns the addresses
	wire cpu_owns_ctl = control_write_owner_q & address_write_owner_q;
	wire cpu_owns_addr = address_write_owner_q;

	// Owner's write to the stored control fields
	wire ctl_wr = cpu_owns_ctl ? cpu_wr_ctl : host_wr_ctl;
	wire [31:0] ctl_wdata = cpu_owns_ctl ? cpu_req.wdata : host_req.wdata;

	// Dual mode is implied while the processor owns the addresses
	wire dual_eff = dual_address_mode_q | cpu_owns_addr;
	wire host_hits_read = dual_eff & address_reg_select_q;

	// ----------------------------------------
	// Address register writes
	// ----------------------------------------
	wire host_addr_ok = host_wr_addr & ~cpu_owns_addr;
	wire [1:0] addr_we;
	wire [ADDR_W-1:0] addr_wdata;

	// Shared mode writes both, so host reads match either transfer
	assign addr_we[0] = cpu_owns_addr ? cpu_wr_aw :
		host_addr_ok & ~host_hits_read;
	assign addr_we[1] = cpu_owns_addr ? cpu_wr_ar :
		host_addr_ok & (host_hits_read | ~dual_eff);
	assign addr_wdata = cpu_owns_addr ? cpu_req.wdata[ADDR_W-1:0] :
		host_req.wdata[ADDR_W-1:0];

	addr_pair #(
		.ADDR_W(ADDR_W)
	) u_addr_pair (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.soft_rst(soft_rst_q),
		.we(addr_we),
		.wdata(addr_wdata),
		.q(addr_q)
	);

	// ----------------------------------------
	// Interrupt flags
	// ----------------------------------------
	// Any party may write these bits, owner or not
	wire host_int_set = cpu_wr_ctl & cpu_req.wdata[BIT_HOST_INT];
	wire host_int_clr = host_wr_ctl & host_req.wdata[BIT_HOST_INT];
	wire proc_int_set = host_wr_ctl & host_req.wdata[BIT_PROC_INT];
	wire proc_int_clr = cpu_wr_ctl & cpu_req.wdata[BIT_PROC_INT];

	// Hardware reset clears the flag at once
	sticky_flag u_host_int (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.set(host_int_set),
		.clr(host_int_clr | soft_rst_q),
		.q(host_int_flag)
	);

	sticky_flag u_proc_int (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.set(proc_int_set),
		.clr(proc_int_clr | soft_rst_q),
		.q(proc_int_flag)
	);

	// ----------------------------------------
	// Read values
	// ----------------------------------------
	wire [31:0] ctl_rd_value;
	assign ctl_rd_value = {
		20'h00000,
		address_reg_select_q,
		1'b0,
		dual_address_mode_q,
		halfword_order_status_q,
		3'h0,
		1'b0,
		1'b1,
		host_int_flag,
		proc_int_flag,
		halfword_order_q
	};

	wire [31:0] own_rd_value;
	assign own_rd_value = {
		22'h000000,
		control_write_owner_q,
		address_write_owner_q,
		burst_write_timeout_q
	};

	wire [31:0] aw_rd = 32'(addr_q[0]);
	wire [31:0] ar_rd = 32'(addr_q[1]);
	wire [31:0] host_addr_rd = host_hits_read ? ar_rd : aw_rd;

	wire [31:0] cpu_rd_mux =
		cpu_req.addr == OFS_CONTROL ? ctl_rd_value :
		cpu_req.addr == OFS_WRITE_ADDR ? aw_rd :
		cpu_req.addr == OFS_READ_ADDR ? ar_rd :
		cpu_req.addr == OFS_OWNERSHIP ? own_rd_value :
		32'h0000_0000;

	wire [31:0] host_rd_mux =
		host_req.addr == OFS_CONTROL ? ctl_rd_value :
		host_req.addr == OFS_WRITE_ADDR ? host_addr_rd :
		32'h0000_0000;

	// ----------------------------------------
	// Control fields
	// ----------------------------------------
	// Soft reset restores defaults but not the ownership register
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			address_reg_select_q <= 1'b0;
			dual_address_mode_q <= 1'b0;
			halfword_order_q <= 1'b0;
			halfword_order_status_q <= 1'b0;
		end else if (soft_rst_q) begin
			address_reg_select_q <= 1'b0;
			dual_address_mode_q <= 1'b0;
			halfword_order_q <= 1'b0;
			halfword_order_status_q <= 1'b0;
		end else if (ctl_wr) begin
			address_reg_select_q <= ctl_wdata[BIT_ADDR_SEL];
			dual_address_mode_q <= ctl_wdata[BIT_DUAL_MODE];
			halfword_order_q <= ctl_wdata[BIT_HWO];
			halfword_order_status_q <= ctl_wdata[BIT_HWO];
		end
	end

	// ----------------------------------------
	// Ownership and time-out
	// ----------------------------------------
	// Only the processor side reaches this register
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			control_write_owner_q <= 1'b0;
			address_write_owner_q <= 1'b0;
			burst_write_timeout_q <= TIMEOUT_RESET;
		end else if (cpu_wr_own) begin
			control_write_owner_q <= cpu_req.wdata[BIT_CTL_OWNER];
			address_write_owner_q <= cpu_req.wdata[BIT_ADDR_OWNER];
			burst_write_timeout_q <= cpu_req.wdata[TIMEOUT_W-1:0];
		end
	end

	// ----------------------------------------
	// Pulses, pin and read data
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			fetch_req_q <= 1'b0;
			soft_rst_q <= 1'b0;
			host_int_n_q <= 1'b1;
			cpu_rdata_q <= 32'h0000_0000;
			host_rdata_q <= 32'h0000_0000;
		end else begin
			fetch_req_q <= host_wr_ctl & host_req.wdata[BIT_FETCH];
			soft_rst_q <= (cpu_wr_rst & cpu_req.wdata[BIT_SOFT_RESET]) |
				(host_wr_rst & host_req.wdata[BIT_SOFT_RESET]);
			host_int_n_q <= ~host_int_flag;
			cpu_rdata_q <= cpu_req.rd ? cpu_rd_mux : 32'h0000_0000;
			host_rdata_q <= host_req.rd ? host_rd_mux : 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign cpu_rdata = cpu_rdata_q;
	assign host_rdata = host_rdata_q;
	assign host_int_n = host_int_n_q;
	assign proc_irq = proc_int_flag;
	assign fetch_req = fetch_req_q;
	assign port_soft_reset = soft_rst_q;
	assign halfword_order = halfword_order_q;
	assign burst_write_timeout = burst_write_timeout_q;
	assign write_address = addr_q[0];
	assign read_address = addr_q[1];

endmodule

// ---- bench/host_model.sv ----
// Host side model driving the host register port of the block.
// Assumes the block answers host reads one cycle after the strobe edge.
module host_model
	import port_ctl_pkg::*;
(
	input wire logic ref_clk,
	output reg_req_t host_req,
	input wire logic [31:0] host_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// Host cycles, optionally slowed by gap
	// ----------------------------------------
	int gap = 0;
	initial host_req = '0;
	task automatic hwr(input logic [7:0] a, input logic [31:0] d);
		if (a == OFS_CONTROL)
			d &= 32'h0000_0b1f;
		repeat (gap) @(posedge ref_clk);
		@(posedge ref_clk);
		host_req <= '{1'b1, 1'b0, a, d};
		@(posedge ref_clk);
		host_req <= '0;
		#1;
	endtask
	task automatic hrd(input logic [7:0] a, output logic [31:0] d);
		repeat (gap) @(posedge ref_clk);
		@(posedge ref_clk);
		host_req <= '{1'b0, 1'b1, a, 32'h0};
		@(posedge ref_clk);
		host_req <= '0;
		#1;
		d = host_rdata;
	endtask
endmodule

// ---- bench/host_port_control_regs_checker.sv ----
// Port-level checks of the host port control registers.
// Assumes it is bound to the top module; one clock, async reset.
module host_port_control_regs_checker
	import port_ctl_pkg::*;
#(
	parameter int ADDR_W = 32
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire reg_req_t cpu_req,
	input wire logic [31:0] cpu_rdata,
	input wire reg_req_t host_req,
	input wire logic [31:0] host_rdata,
	input wire logic host_int_n,
	input wire logic proc_irq,
	input wire logic fetch_req,
	input wire logic port_soft_reset,
	input wire logic halfword_order,
	input wire logic [TIMEOUT_W-1:0] burst_write_timeout,
	input wire logic [ADDR_W-1:0] write_address,
	input wire logic [ADDR_W-1:0] read_address
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	wire host_ctl_wr = host_req.wr && host_req.addr == OFS_CONTROL;
	wire cpu_ctl_wr = cpu_req.wr && cpu_req.addr == OFS_CONTROL;
	wire own_wr = cpu_req.wr && cpu_req.addr == OFS_OWNERSHIP;
	logic own_ctl_q;
	logic own_addr_q;
	// Ownership as software set it; soft reset leaves it alone
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			own_ctl_q <= 1'b0;
			own_addr_q <= 1'b0;
		end else if (own_wr) begin
			own_ctl_q <= cpu_req.wdata[BIT_CTL_OWNER];
			own_addr_q <= cpu_req.wdata[BIT_ADDR_OWNER];
		end
	end
	// Only the owning side may move the stored fields
	wire ctl_owner_wr = (own_ctl_q && own_addr_q) ? cpu_ctl_wr : host_ctl_wr;
	wire wa_wr = own_addr_q ?
		(cpu_req.wr && cpu_req.addr == OFS_WRITE_ADDR) :
		(host_req.wr && host_req.addr == OFS_WRITE_ADDR);
	property p_fetch;
		host_ctl_wr && host_req.wdata[BIT_FETCH] |=> fetch_req;
	endproperty
	property p_fetch_src;
		!(host_ctl_wr && host_req.wdata[BIT_FETCH]) |=> !fetch_req;
	endproperty
	property p_ctl_read;
		cpu_req.rd && cpu_req.addr == OFS_CONTROL |=> !cpu_rdata[BIT_FETCH]
			&& cpu_rdata[BIT_HWO_STATUS] == cpu_rdata[BIT_HWO];
	endproperty
	property p_host_interrupt_set;
		cpu_ctl_wr && cpu_req.wdata[BIT_HOST_INT] |-> ##2 !host_int_n;
	endproperty
	property p_host_interrupt_clr;
		host_ctl_wr && host_req.wdata[BIT_HOST_INT] && !cpu_ctl_wr
			|-> ##2 host_int_n;
	endproperty
	property p_irq;
		host_ctl_wr && host_req.wdata[BIT_PROC_INT] |=> proc_irq;
	endproperty
	property p_hwo;
		$changed(halfword_order) |-> port_soft_reset
			|| $past(ctl_owner_wr || port_soft_reset);
	endproperty
	property p_addr;
		$changed(write_address) |-> port_soft_reset
			|| $past(wa_wr || port_soft_reset);
	endproperty
	property p_keep_to;
		port_soft_reset && !cpu_req.wr |=> $stable(burst_write_timeout);
	endproperty
	a_fetch: assert property (p_fetch) else $error("no fetch pulse");
	a_fetch_src: assert property (p_fetch_src) else $error("stray fetch");
	a_ctl_read: assert property (p_ctl_read) else $error("ctl read");
	a_host_interrupt_set: assert property (p_host_interrupt_set) else $error("pin high");
	a_host_interrupt_clr: assert property (p_host_interrupt_clr) else $error("pin low");
	a_irq: assert property (p_irq) else $error("no proc irq");
	a_hwo: assert property (p_hwo) else $error("order changed");
	a_addr: assert property (p_addr) else $error("address changed");
	a_keep_to: assert property (p_keep_to) else $error("timeout lost");
	c_fetch: cover property (fetch_req);
	c_soft: cover property (port_soft_reset);
	c_host_interrupt: cover property ($fell(host_int_n));
endmodule

bind host_port_control_regs host_port_control_regs_checker #(
	.ADDR_W(ADDR_W)
) host_port_control_regs_checker_inst (.ref_clk, .arst_n, .cpu_req,
	.cpu_rdata, .host_req, .host_rdata, .host_int_n, .proc_irq, .fetch_req,
	.port_soft_reset, .halfword_order, .burst_write_timeout,
	.write_address, .read_address);

// ---- bench/host_port_control_regs_tb.sv ----
// Testbench of the host port control registers.
// Assumes the checker is bound and the host model drives the host port.
module host_port_control_regs_tb
	import port_ctl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	reg_req_t cpu_req = '0;
	reg_req_t host_req;
	logic [31:0] cpu_rdata, host_rdata, d;
	logic host_int_n, proc_irq, fetch_req, port_soft_reset, halfword_order;
	logic [TIMEOUT_W-1:0] burst_write_timeout;
	logic [31:0] write_address, read_address;
	int n_fail = 0;
	int n_checks = 0;
	always #20 ref_clk = ~ref_clk;
	host_port_control_regs host_port_control_regs_inst (.ref_clk, .arst_n,
		.cpu_req, .cpu_rdata, .host_req, .host_rdata, .host_int_n,
		.proc_irq, .fetch_req, .port_soft_reset, .halfword_order,
		.burst_write_timeout, .write_address, .read_address);
	host_model host_model_inst (.ref_clk, .host_req, .host_rdata);
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input string n, input logic [31:0] e, g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cwr(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		cpu_req <= '{1'b1, 1'b0, a, v};
		@(posedge ref_clk);
		cpu_req <= '0;
		#1;
	endtask
	task automatic crd(input logic [7:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		cpu_req <= '{1'b0, 1'b1, a, 32'h0};
		@(posedge ref_clk);
		cpu_req <= '0;
		#1;
		chk("cpu read", e, cpu_rdata);
	endtask
	task automatic tick;
		@(posedge ref_clk);
		#1;
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Guard against a hung sequence
	initial begin
		repeat (3000) @(posedge ref_clk);
		n_fail++;
		close_out;
	end
	initial begin
		// Initialiser gives no reset edge; wait for a clocked reset
		@(posedge ref_clk);
		#1;
		chk("pin in reset", 32'h1, host_int_n);
		repeat (3) @(posedge ref_clk);
		arst_n <= 1'b1;
		crd(OFS_CONTROL, 32'h8);
		host_model_inst.hwr(OFS_CONTROL, 32'h1);
		chk("order", 32'h1, halfword_order);
		crd(OFS_CONTROL, 32'h109);
		host_model_inst.hwr(OFS_WRITE_ADDR, 32'hffff_ffff);
		chk("wa", 32'hffff_ffff, write_address);
		chk("ra", 32'hffff_ffff, read_address);
		host_model_inst.hwr(OFS_CONTROL, 32'h201);
		host_model_inst.hwr(OFS_WRITE_ADDR, 32'ha5a5_5a5a);
		chk("ra", 32'hffff_ffff, read_address);
		host_model_inst.hwr(OFS_CONTROL, 32'ha01);
		host_model_inst.hwr(OFS_WRITE_ADDR, 32'h1234_5678);
		chk("wa", 32'ha5a5_5a5a, write_address);
		host_model_inst.hrd(OFS_WRITE_ADDR, d);
		chk("host ra", 32'h1234_5678, d);
		$display("address modes done");
		host_model_inst.hwr(OFS_CONTROL, 32'ha11);
		chk("fetch", 32'h1, fetch_req);
		cwr(OFS_CONTROL, 32'h10);
		chk("cpu fetch", 32'h0, fetch_req);
		cwr(OFS_CONTROL, 32'h4);
		tick;
		chk("pin", 32'h0, host_int_n);
		host_model_inst.hrd(OFS_CONTROL, d);
		chk("host ctl", 32'hb0d, d);
		host_model_inst.gap = 3;
		host_model_inst.hwr(OFS_CONTROL, 32'ha05);
		tick;
		chk("pin", 32'h1, host_int_n);
		host_model_inst.hwr(OFS_CONTROL, 32'ha03);
		host_model_inst.gap = 0;
		host_model_inst.hwr(OFS_CONTROL, 32'ha01);
		chk("irq", 32'h1, proc_irq);
		cwr(OFS_CONTROL, 32'h2);
		chk("irq", 32'h0, proc_irq);
		host_model_inst.hwr(OFS_CONTROL, 32'ha03);
		chk("irq", 32'h1, proc_irq);
		$display("interrupts done");
		cwr(OFS_OWNERSHIP, 32'h1ab);
		chk("timeout", 32'hab, burst_write_timeout);
		host_model_inst.hwr(OFS_WRITE_ADDR, 32'h0);
		chk("wa", 32'ha5a5_5a5a, write_address);
		cwr(OFS_WRITE_ADDR, 32'h1111_1111);
		cwr(OFS_READ_ADDR, 32'h2222_2222);
		chk("wa", 32'h1111_1111, write_address);
		chk("ra", 32'h2222_2222, read_address);
		cwr(OFS_CONTROL, 32'h0);
		chk("order", 32'h1, halfword_order);
		cwr(OFS_OWNERSHIP, 32'h3ab);
		cwr(OFS_CONTROL, 32'h800);
		chk("order", 32'h0, halfword_order);
		host_model_inst.hrd(OFS_WRITE_ADDR, d);
		chk("host ra", 32'h2222_2222, d);
		host_model_inst.hwr(OFS_CONTROL, 32'h1);
		chk("order", 32'h0, halfword_order);
		crd(8'h44, 32'h0);
		host_model_inst.hrd(OFS_OWNERSHIP, d);
		chk("host own", 32'h0, d);
		$display("ownership done");
		host_model_inst.hwr(OFS_SOFT_RESET, 32'h1);
		chk("soft", 32'h1, port_soft_reset);
		tick;
		chk("wa", 32'h0, write_address);
		chk("irq", 32'h0, proc_irq);
		chk("timeout", 32'hab, burst_write_timeout);
		cwr(OFS_CONTROL, 32'h4);
		tick;
		chk("pin", 32'h0, host_int_n);
		cwr(OFS_SOFT_RESET, 32'h1);
		chk("soft", 32'h1, port_soft_reset);
		tick;
		tick;
		chk("pin", 32'h1, host_int_n);
		cwr(OFS_CONTROL, 32'h4);
		tick;
		chk("pin", 32'h0, host_int_n);
		arst_n <= 1'b0;
		#1;
		chk("pin", 32'h1, host_int_n);
		$display("resets done");
		close_out;
	end
endmodule
